// *** src/cgi_geom_reg.sv ***
// Registered geometry word for one cache of a given build-time size
`timescale 1ns/100ps
`default_nettype none

module cgi_geom_reg
#(
    parameter int unsigned SIZE_KB = 8
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // Geometry word
    output logic [31:0]      geom_word
);
    import cgi_pkg::*;

    localparam logic [31:0] GEOM_VALUE = cgi_geom_word(SIZE_KB);

    // ==========================================================
    // Word register
    // Held in a flop so the read mux sees a clean registered source
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            geom_word <= GEOM_VALUE;
        else
            geom_word <= GEOM_VALUE;
    end

    // ==========================================================
    // Checks
    default clocking geom_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    geom_fixed_a: assert property (
        geom_word[CGI_SETS_LSB-1:0] == 13'h0019 &&
        geom_word[31:CGI_POLICY_LSB] == 4'hf &&
        geom_word[CGI_SETS_LSB +: CGI_SETS_W] == 15'(SIZE_KB * 8 - 1))
        else $error("geometry word does not match cache size");

endmodule

`default_nettype wire

// *** src/cgi_id_regs.sv ***
// Cache geometry and cache level identification registers
//
// Summary of operation
// - Geometry register read-only, privileged only
// - Bits 31 to 28 always read one
// - Bits 27:13 hold selected set count minus one
// - Bits 12:3 hold ways minus one, three
// - Line code in bits 2:0 reads one
// - Full words for 4, 8, 16 KB
// - Full words for 32 and 64 KB
// - Selection register picks which cache reports
// - Geometry read at opcode 1, c0, c0, 0
// - Level register read-only, privileged only
// - Unification and coherency levels both read one
// - Top bits and levels two to eight zero
// - Bit 2 zero, no unified cache
// - Bits 1, 0 flag data, instruction caches
// - Level read at opcode 1, c0, c0, 1
// - Selection bit 0: one instruction, zero data
// - Selection level field reads zero, ignores writes
`timescale 1ns/100ps
`default_nettype none

module cgi_id_regs
#(
    parameter int unsigned DCACHE_KB      = 8,
    parameter int unsigned ICACHE_KB      = 8,
    parameter bit          DCACHE_PRESENT = 1'b1,
    parameter bit          ICACHE_PRESENT = 1'b1
)
(
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    // Coprocessor access request
    input  wire logic                              cp_req,
    input  wire logic                              cp_write,
    input  wire logic                              cp_priv,
    input  wire logic [cgi_pkg::CGI_OPC1_W-1:0]    cp_opc1,
    input  wire logic [cgi_pkg::CGI_CRN_W-1:0]     cp_crn,
    input  wire logic [cgi_pkg::CGI_CRM_W-1:0]     cp_crm,
    input  wire logic [cgi_pkg::CGI_OPC2_W-1:0]    cp_opc2,
    input  wire logic [31:0]                       cp_wdata,
    // Coprocessor access answer
    output logic                                   cp_ack,
    output logic                                   cp_undef,
    output logic [31:0]                            cp_rdata
);
    import cgi_pkg::*;

    localparam logic [31:0] LEVEL_VALUE =
        cgi_level_word(DCACHE_PRESENT, ICACHE_PRESENT);
    localparam logic [CGI_SETS_W-1:0] D_SETS = cgi_sets_m1(DCACHE_KB);
    localparam logic [CGI_SETS_W-1:0] I_SETS = cgi_sets_m1(ICACHE_KB);

    // ==========================================================
    // Access decode
    function automatic logic cgi_match(
        input logic [2:0] opc1,
        input logic [3:0] crn,
        input logic [3:0] crm,
        input logic [2:0] opc2,
        input logic [2:0] want_opc1,
        input logic [2:0] want_opc2
    );
        return opc1 == want_opc1 && crn == CGI_CRN_ID &&
               crm == CGI_CRM_ID && opc2 == want_opc2;
    endfunction

    logic        hit_geom;
    logic        hit_level;
    logic        hit_sel;
    logic        any_hit;
    logic        deny;
    logic        sel_q;
    logic [31:0] geom_words [2];
    logic [31:0] read_mux;

    assign hit_geom  = cp_req && cgi_match(cp_opc1, cp_crn, cp_crm, cp_opc2,
                       CGI_OPC1_ID, CGI_OPC2_GEOM);
    assign hit_level = cp_req && cgi_match(cp_opc1, cp_crn, cp_crm, cp_opc2,
                       CGI_OPC1_ID, CGI_OPC2_LEVEL);
    assign hit_sel   = cp_req && cgi_match(cp_opc1, cp_crn, cp_crm, cp_opc2,
                       CGI_OPC1_SEL, CGI_OPC2_SEL);
    assign any_hit   = hit_geom || hit_level || hit_sel;

    // Writes to the identification words are refused rather than dropped
    // silently, so software learns it tried to alter a constant
    assign deny = !cp_priv ||
                  (cp_write && (hit_geom || hit_level));

    // ==========================================================
    // Cache size selection
    // Only the instruction/data bit is stored; the level field is a
    // constant, so writes to it have nowhere to land
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            sel_q <= CGI_SEL_RESET;
        else if (hit_sel && cp_write && cp_priv)
            sel_q <= cp_wdata[CGI_SEL_I_BIT];
    end

    // ==========================================================
    // Per-cache geometry words
    generate
        for (genvar gi = 0; gi < 2; gi++)
        begin : g_geom
            cgi_geom_reg
            #(
                .SIZE_KB (gi == 0 ? DCACHE_KB : ICACHE_KB)
            )
            u_geom
            (
                .clk       (clk),
                .sys_rst   (sys_rst),
                .geom_word (geom_words[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Read data select
    always_comb
    begin
        read_mux = 32'h00000000;
        if (deny)
            read_mux = 32'h00000000;
        else if (hit_geom)
            read_mux = geom_words[sel_q];
        else if (hit_level)
            read_mux = LEVEL_VALUE;
        else if (hit_sel)
            read_mux = {28'h0000000, CGI_SEL_LVL_ONE, sel_q};
    end

    // ==========================================================
    // Answer registers
    // One cycle of latency for every decoded access; the core stalls on cp_ack
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cp_ack <= 1'b0;
        else
            cp_ack <= any_hit;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cp_undef <= 1'b0;
        else
            cp_undef <= any_hit && deny;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cp_rdata <= 32'h00000000;
        else if (any_hit)
            cp_rdata <= read_mux;
        else
            cp_rdata <= 32'h00000000;
    end

    // ==========================================================
    // Checks
    default clocking id_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic geom_ok;
    logic level_ok;
    assign geom_ok  = hit_geom && !deny;
    assign level_ok = hit_level && !deny;

    sequence sel_instr_write;
        hit_sel && cp_write && cp_priv && cp_wdata[0];
    endsequence

    sequence sel_data_write;
        hit_sel && cp_write && cp_priv && !cp_wdata[0];
    endsequence

    sequence geom_read;
        geom_ok;
    endsequence

    geom_ro_a: assert property (
        hit_geom && cp_write |=> cp_ack && cp_undef && cp_rdata == 32'h0)
        else $error("write to geometry word not refused");

    geom_policy_a: assert property (
        geom_read |=> cp_ack && !cp_undef && cp_rdata[31:28] == 4'hf)
        else $error("policy bits of geometry word not all one");

    geom_sets_a: assert property (
        geom_read |=> cp_rdata[27:13] == ($past(sel_q) ? I_SETS : D_SETS))
        else $error("set count field wrong for selected cache");

    geom_ways_line_a: assert property (
        geom_read |=> cp_rdata[12:3] == 10'h003 && cp_rdata[2:0] == 3'h1)
        else $error("ways or line code field wrong");

    geom_word_a: assert property (
        geom_read |=> cp_rdata == cgi_geom_word(
            $past(sel_q) ? ICACHE_KB : DCACHE_KB))
        else $error("geometry word wrong for cache size");

    geom_big_a: assert property (
        geom_read ##0 (ICACHE_KB == 64 && sel_q) |=> cp_rdata == 32'hf03fe019)
        else $error("64 KB geometry word wrong");

    select_instr_a: assert property (
        sel_instr_write ##1 geom_read |=> cp_rdata[27:13] == I_SETS)
        else $error("instruction select not honoured");

    select_data_a: assert property (
        sel_data_write ##1 geom_read |=> cp_rdata[27:13] == D_SETS)
        else $error("data select not honoured");

    level_word_a: assert property (
        level_ok |=> cp_ack && cp_rdata[29:24] == 6'h09 &&
        cp_rdata[31:30] == 2'h0 && cp_rdata[23:2] == 22'h0 &&
        cp_rdata[1] == DCACHE_PRESENT && cp_rdata[0] == ICACHE_PRESENT)
        else $error("cache level word wrong");

    level_ro_a: assert property (
        hit_level && cp_write ##1 hit_level && !cp_write && cp_priv
        |=> cp_rdata == LEVEL_VALUE)
        else $error("level word changed by a write");

    sel_level_a: assert property (
        hit_sel && !cp_write && cp_priv |=> cp_rdata[3:1] == 3'h0)
        else $error("selection level field not zero");

    unpriv_undef_a: assert property (
        any_hit && !cp_priv |=> cp_undef && cp_rdata == 32'h0)
        else $error("unprivileged access returned data");

    no_hit_a: assert property (
        !any_hit |=> !cp_ack && !cp_undef)
        else $error("answer without a decoded access");

    // ==========================================================
    // Complete words per cache size, kept apart from the encoder
    // so that a slip in the field packing cannot hide itself
    function automatic logic [31:0] cgi_size_word(input int unsigned kb);
        case (kb)
            32'h4:
                return 32'hf003e019;
            32'h8:
                return 32'hf007e019;
            32'h10:
                return 32'hf00fe019;
            32'h20:
                return 32'hf01fe019;
            32'h40:
                return 32'hf03fe019;
            default:
                return 32'h00000000;
        endcase
    endfunction

    sequence geom_read_data;
        geom_ok && !sel_q;
    endsequence

    sequence geom_read_instr;
        geom_ok && sel_q;
    endsequence

    sequence sel_write;
        hit_sel && cp_write && cp_priv;
    endsequence

    // ==========================================================
    // Checks against the size table, the fields and the answer
    table_data_a: assert property (
        geom_read_data |=> cp_rdata == cgi_size_word(DCACHE_KB))
        else $error("data cache word differs from size table");

    table_instr_a: assert property (
        geom_read_instr |=> cp_rdata == cgi_size_word(ICACHE_KB))
        else $error("instruction cache word differs from size table");

    src_data_a: assert property (
        geom_words[0] == cgi_size_word(DCACHE_KB))
        else $error("data cache geometry source wrong");

    src_instr_a: assert property (
        geom_words[1] == cgi_size_word(ICACHE_KB))
        else $error("instruction cache geometry source wrong");

    geom_line_a: assert property (
        geom_read |=> cp_rdata[2:0] == 3'h1)
        else $error("line code field not eight words");

    level_top_a: assert property (
        level_ok |=> cp_rdata[31:30] == 2'h0 && cp_rdata[23:3] == 21'h0)
        else $error("unused level fields not zero");

    level_unified_a: assert property (
        level_ok |=> !cp_rdata[2])
        else $error("unified cache reported at level one");

    level_present_a: assert property (
        level_ok |=> cp_rdata[1:0] == {DCACHE_PRESENT, ICACHE_PRESENT})
        else $error("cache presence bits wrong");

    level_write_a: assert property (
        hit_level && cp_write |=> cp_ack && cp_undef && cp_rdata == 32'h0)
        else $error("write to level word not refused");

    ack_answer_a: assert property (
        any_hit |=> cp_ack)
        else $error("decoded access not answered");

    quiet_rdata_a: assert property (
        !any_hit |=> cp_rdata == 32'h0)
        else $error("read data without a decoded access");

    undef_ack_a: assert property (
        cp_undef |-> cp_ack)
        else $error("undefined flag without answer");

    sel_store_a: assert property (
        sel_write |=> cp_ack && !cp_undef &&
        sel_q == $past(cp_wdata[CGI_SEL_I_BIT]))
        else $error("selection write not stored");

    sel_hold_a: assert property (
        !(hit_sel && cp_write && cp_priv) |=> $stable(sel_q))
        else $error("selection changed without a write");

    sel_read_a: assert property (
        hit_sel && !cp_write && cp_priv |=> cp_rdata == {31'h0, $past(sel_q)})
        else $error("selection read returned wrong choice");

endmodule

`default_nettype wire

// *** src/cgi_pkg.sv ***
// Shared constants and encoders for the cache geometry identification block
`default_nettype none

package cgi_pkg;

    // ==========================================================
    // Coprocessor access encodings
    localparam int unsigned CGI_OPC1_W      = 3;
    localparam int unsigned CGI_CRN_W       = 4;
    localparam int unsigned CGI_CRM_W       = 4;
    localparam int unsigned CGI_OPC2_W      = 3;
    localparam logic [2:0]  CGI_OPC1_ID     = 3'h1;
    localparam logic [2:0]  CGI_OPC1_SEL    = 3'h2;
    localparam logic [3:0]  CGI_CRN_ID      = 4'h0;
    localparam logic [3:0]  CGI_CRM_ID      = 4'h0;
    localparam logic [2:0]  CGI_OPC2_GEOM   = 3'h0;
    localparam logic [2:0]  CGI_OPC2_LEVEL  = 3'h1;
    localparam logic [2:0]  CGI_OPC2_SEL    = 3'h0;

    // ==========================================================
    // Cache geometry word layout
    localparam int unsigned CGI_POLICY_LSB  = 28;
    localparam int unsigned CGI_SETS_LSB    = 13;
    localparam int unsigned CGI_SETS_W      = 15;
    localparam int unsigned CGI_WAYS_LSB    = 3;
    localparam int unsigned CGI_WAYS_W      = 10;
    localparam int unsigned CGI_LINE_LSB    = 0;
    localparam int unsigned CGI_LINE_W      = 3;
    // Write-through, write-back, read alloc, write alloc, all supported
    localparam logic [3:0]  CGI_POLICY_ALL  = 4'hf;
    localparam logic [9:0]  CGI_WAYS_M1     = 10'h003;
    localparam logic [2:0]  CGI_LINE_CODE   = 3'h1;
    // Four ways of eight-word lines: 128 bytes per set, 8 sets per KB
    localparam int unsigned CGI_SETS_PER_KB = 8;

    // ==========================================================
    // Cache level word layout
    localparam int unsigned CGI_LOU_LSB     = 27;
    localparam int unsigned CGI_LOC_LSB     = 24;
    localparam logic [2:0]  CGI_LEVEL_ONE   = 3'h1;
    localparam int unsigned CGI_CL1_UNI_BIT = 2;
    localparam int unsigned CGI_CL1_D_BIT   = 1;
    localparam int unsigned CGI_CL1_I_BIT   = 0;

    // ==========================================================
    // Cache size selection word layout
    localparam int unsigned CGI_SEL_I_BIT   = 0;
    localparam int unsigned CGI_SEL_LVL_LSB = 1;
    localparam logic [2:0]  CGI_SEL_LVL_ONE = 3'h0;
    localparam logic        CGI_SEL_RESET   = 1'b0;

    typedef enum logic
    {
        CGI_CACHE_DATA  = 1'b0,
        CGI_CACHE_INSTR = 1'b1
    } cgi_cache_e;

    // ==========================================================
    // Encoders
    function automatic logic [CGI_SETS_W-1:0] cgi_sets_m1(
        input int unsigned kb
    );
        return CGI_SETS_W'(kb * CGI_SETS_PER_KB - 1);
    endfunction

    function automatic logic [31:0] cgi_geom_word(input int unsigned kb);
        return {CGI_POLICY_ALL, cgi_sets_m1(kb), CGI_WAYS_M1, CGI_LINE_CODE};
    endfunction

    function automatic logic [31:0] cgi_level_word(
        input logic d_present,
        input logic i_present
    );
        return {2'h0, CGI_LEVEL_ONE, CGI_LEVEL_ONE, 21'h000000, 1'b0,
                d_present, i_present};
    endfunction

endpackage

`default_nettype wire

// *** test/cgi_id_regs_tb_top.sv ***
// Self-checking bench for the cache geometry and level identification words
`timescale 1ns/100ps
`default_nettype none

module cgi_id_regs_tb_top;
    import cgi_pkg::*;

    // ==========================================================
    // Build choice: caches of different sizes, no instruction cache
    localparam int unsigned DKB     = 4;
    localparam int unsigned IKB     = 64;
    localparam bit          DPRES   = 1'b1;
    localparam bit          IPRES   = 1'b0;
    localparam int          MAX_CYC = 3000;

    logic        clk      = 1'b0;
    logic        sys_rst  = 1'b1;
    logic        cp_req   = 1'b0;
    logic        cp_write = 1'b0;
    logic        cp_priv  = 1'b0;
    logic [2:0]  cp_opc1  = 3'h0;
    logic [3:0]  cp_crn   = 4'h0;
    logic [3:0]  cp_crm   = 4'h0;
    logic [2:0]  cp_opc2  = 3'h0;
    logic [31:0] cp_wdata = 32'h0;
    logic        cp_ack;
    logic        cp_undef;
    logic [31:0] cp_rdata;
    int          miscompares = 0;
    int          checks      = 0;
    int          cyc         = 0;
    int          sel_m       = 0;
    logic [31:0] rnd         = 32'h3ee3;
    logic [31:0] r;
    logic [31:0] exp_q [$];

    cgi_id_regs #(
        .DCACHE_KB      (DKB),
        .ICACHE_KB      (IKB),
        .DCACHE_PRESENT (DPRES),
        .ICACHE_PRESENT (IPRES)
    ) cgi_id_regs_inst (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .cp_req   (cp_req),
        .cp_write (cp_write),
        .cp_priv  (cp_priv),
        .cp_opc1  (cp_opc1),
        .cp_crn   (cp_crn),
        .cp_crm   (cp_crm),
        .cp_opc2  (cp_opc2),
        .cp_wdata (cp_wdata),
        .cp_ack   (cp_ack),
        .cp_undef (cp_undef),
        .cp_rdata (cp_rdata)
    );

    always #25 clk = ~clk;

    // ==========================================================
    // Hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == MAX_CYC)
        begin
            miscompares++;
            end_sim();
        end
    end

    // ==========================================================
    // Helpers and reference model
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] next_rnd();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    // Four ways, eight-word lines, all policies supported
    function automatic logic [31:0] geom_m(input int kb);
        return 32'hf000_0000 | 32'((kb * 8 - 1) << 13) | 32'h19;
    endfunction

    // Outputs are looked at in the cycle after the taking edge
    task automatic acc(input logic w, input logic p, input logic [2:0] o1,
                       input logic [3:0] n, input logic [3:0] m,
                       input logic [2:0] o2, input logic [31:0] wd);
        logic        dec;
        logic        e_und;
        logic [31:0] e_rd;
        dec = n == 4'h0 && m == 4'h0 &&
              ((o1 == 3'h1 && o2 <= 3'h1) || (o1 == 3'h2 && o2 == 3'h0));
        e_und = dec && (!p || (w && o1 == 3'h1));
        e_rd = 32'h0;
        // A selection write answers with the choice it replaces
        if (dec && !e_und && o1 == 3'h2)
        begin
            e_rd = 32'(sel_m);
            if (w)
                sel_m = int'(wd[0]);
        end
        else if (dec && !e_und && o2 == 3'h0)
            e_rd = geom_m(sel_m != 0 ? IKB : DKB);
        else if (dec && !e_und)
            e_rd = 32'h0900_0000 | {30'h0, DPRES, IPRES};
        exp_q.push_back(e_rd);
        cp_req = 1'b1;
        cp_write = w;
        cp_priv = p;
        cp_opc1 = o1;
        cp_crn = n;
        cp_crm = m;
        cp_opc2 = o2;
        cp_wdata = wd;
        @(negedge clk);
        check({31'h0, cp_ack}, {31'h0, dec});
        check({31'h0, cp_undef}, {31'h0, e_und});
        check(cp_rdata, exp_q.pop_front());
    endtask

    task automatic idle();
        cp_req = 1'b0;
        @(negedge clk);
        check({30'h0, cp_ack, cp_undef}, 32'h0);
        check(cp_rdata, 32'h0);
    endtask

    // A request held during reset must not be answered
    task automatic do_reset();
        sys_rst = 1'b1;
        cp_req = 1'b1;
        cp_opc1 = 3'h1;
        repeat (3) @(negedge clk);
        check({30'h0, cp_ack, cp_undef}, 32'h0);
        sys_rst = 1'b0;
        sel_m = 0;
        idle();
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset();
        acc(0, 1, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0);
        check(cp_rdata, 32'hf003e019);
        acc(1, 1, 3'h2, 4'h0, 4'h0, 3'h0, 32'h1);
        acc(0, 1, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0);
        check(cp_rdata, 32'hf03fe019);
        acc(0, 1, 3'h2, 4'h0, 4'h0, 3'h0, 32'h0);
        acc(1, 1, 3'h2, 4'h0, 4'h0, 3'h0, 32'hffff_fffe);
        acc(0, 1, 3'h2, 4'h0, 4'h0, 3'h0, 32'h0);
        acc(0, 1, 3'h1, 4'h0, 4'h0, 3'h1, 32'h0);
        check(cp_rdata, 32'h0900_0002);
        acc(1, 1, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0);
        acc(1, 1, 3'h1, 4'h0, 4'h0, 3'h1, 32'hffff_ffff);
        acc(0, 1, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0);
        acc(0, 0, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0);
        acc(0, 0, 3'h1, 4'h0, 4'h0, 3'h1, 32'h0);
        acc(0, 1, 3'h1, 4'h0, 4'h0, 3'h2, 32'h0);
        acc(0, 1, 3'h1, 4'h0, 4'h1, 3'h0, 32'h0);
        acc(0, 1, 3'h0, 4'h0, 4'h0, 3'h1, 32'h0);
        idle();
        // Random mix, about one in four decoded, often back to back
        repeat (400)
        begin
            r = next_rnd();
            acc(r[22], r[25:23] != 3'h0,
                r[1:0] == 2'h0 ? r[10:8] : (r[2] ? 3'h1 : 3'h2),
                r[7:5] == 3'h0 ? r[14:11] : 4'h0,
                r[17:15] == 3'h0 ? r[21:18] : 4'h0,
                {1'b0, r[4:3]}, next_rnd());
            if (r[26])
                idle();
        end
        // Reset in mid-run returns the selection to the data cache
        acc(1, 1, 3'h2, 4'h0, 4'h0, 3'h0, 32'h1);
        do_reset();
        acc(0, 1, 3'h1, 4'h0, 4'h0, 3'h0, 32'h0);
        check(cp_rdata, 32'hf003e019);
        idle();
        end_sim();
    end

endmodule

`default_nettype wire
